// >>> design/rx_ctrl_pkg.sv
// Constants and types for the receiver control block
package rx_ctrl_pkg;
	// Register file
	localparam int NUM_REGS = 11;
	localparam logic [3:0] LAST_ADDR = 4'hA;
	localparam logic [31:0] REG_RESET [NUM_REGS] = '{
		32'hBEA41603, 32'h20550288, 32'h0EAFA1DC, 32'h698C0008,
		32'h00C00080, 32'h08000070, 32'h08000000, 32'h010061B2,
		32'h01E0F401, 32'h00C00002, 32'h010061B0};
	// Control fields steering the block
	localparam logic [3:0] ADDR_OUT_CTRL = 4'h6;
	localparam int DIG_MODE_BIT = 27;
	localparam int MON_EN_BIT = 26;
	localparam logic [3:0] ADDR_CLK_CTRL = 4'h7;
	localparam int EXT_CLK_BIT = 0;
	// Serial frame: 4 address bits, 1 read bit, 32 data bits, MSB first
	localparam logic [5:0] HEAD_LAST = 6'h04;
	localparam logic [5:0] DATA_LAST = 6'h1F;
	localparam logic [5:0] DATA_BITS = 6'h20;
	// Internal ADC clock: one sample every ADC_DIV_LAST+1 cycles
	localparam logic [2:0] ADC_DIV_LAST = 3'h7;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_HEAD = 2'b01,
		ST_WRITE = 2'b11,
		ST_READ = 2'b10
	} serial_state_e;

	typedef struct packed {
		logic [1:0] i;
		logic [1:0] q;
	} adc_sample_s;
endpackage : rx_ctrl_pkg

// >>> design/rx_ctrl_serial.sv
// Receiver control: three-wire configuration port, registers and control pins
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Incoming serial bits are sampled on each serial clock rising edge.
// - Read data changes on the serial clock falling edge.
// - Three wires only: select, host clock, one shared data line.
// - Lock indicator is high while the PLL is locked, else low.
// - Shutdown low switches every function off except the ADC clock select output.
// - ADCs may be clocked from the external ADC clock input.
// - Digital mode presents Q sample bits 0 and 1.
// - Digital mode presents I sample bits 0 and 1.
// - Analog I goes to the monitor pins only when monitor enable is 1.
// - All configuration registers take their reset values at power-up.
module rx_ctrl_serial
	import rx_ctrl_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic arst_n_in,
	// Three-wire serial link
	input wire logic chip_select_low_in,
	input wire logic serial_clock_in,
	input wire logic serial_data_line_in,
	output logic serial_data_line_out,
	output logic serial_data_line_oe_out,
	// Control and status pins
	input wire logic shutdown_low_in,
	input wire logic pll_locked_in,
	input wire logic external_adc_clock_input_in,
	input wire adc_sample_s adc_sample_in,
	output logic pll_lock_indicator_out,
	output logic adc_ext_clock_sel_out,
	// Sample and monitor outputs
	output logic q_sample_bit_zero_out,
	output logic q_sample_bit_one_out,
	output logic i_sample_bit_zero_out,
	output logic i_sample_bit_one_out,
	output logic analog_monitor_pos_out,
	output logic analog_monitor_neg_out
);
	logic [1:0] rst_pipe_reg;
	logic [9:0] sync1_reg;
	logic [9:0] sync2_reg;
	logic sclk_prev_reg;
	logic cs_prev_reg;
	logic ext_prev_reg;
	serial_state_e state_reg;
	serial_state_e state_next;
	logic [5:0] cnt_reg;
	logic [4:0] head_reg;
	logic [3:0] addr_reg;
	logic [31:0] wr_shift_reg;
	logic [31:0] tx_reg;
	logic [2:0] div_reg;
	logic [31:0] cfg_reg [NUM_REGS];

	// Reset release through two flops
	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in)
			rst_pipe_reg <= 2'b00;
		else
			rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
	end
	wire rst_n = rst_pipe_reg[1];

	// All pins are asynchronous to clk_sys; the link clock is only sampled
	wire [9:0] pins_raw = {chip_select_low_in, serial_clock_in, serial_data_line_in,
		shutdown_low_in, pll_locked_in, external_adc_clock_input_in, adc_sample_in};
	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			// Idle pin levels, so that no false edge follows reset
			sync1_reg <= 10'h240;
			sync2_reg <= 10'h240;
		end else begin
			sync1_reg <= pins_raw;
			sync2_reg <= sync1_reg;
		end
	end
	wire cs_s = sync2_reg[9];
	wire sclk_s = sync2_reg[8];
	wire data_s = sync2_reg[7];
	wire shutdown_low_s = sync2_reg[6];
	wire lock_s = sync2_reg[5];
	wire ext_s = sync2_reg[4];
	adc_sample_s smp_s;
	assign smp_s = sync2_reg[3:0];

	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			sclk_prev_reg <= 1'b0;
			cs_prev_reg <= 1'b1;
			ext_prev_reg <= 1'b0;
		end else begin
			sclk_prev_reg <= sclk_s;
			cs_prev_reg <= cs_s;
			ext_prev_reg <= ext_s;
		end
	end

	// Edge decode; shutdown gates the whole link
	wire sclk_rise = sclk_s & ~sclk_prev_reg;
	wire sclk_fall = ~sclk_s & sclk_prev_reg;
	wire ext_rise = ext_s & ~ext_prev_reg;
	wire selected = shutdown_low_s & ~cs_s;
	wire cs_fall = ~cs_s & cs_prev_reg;
	wire bit_in = selected & sclk_rise;
	wire bit_out = selected & sclk_fall;
	wire head_done = (state_reg == ST_HEAD) & bit_in & (cnt_reg == HEAD_LAST);
	wire head_mapped = head_reg[3:0] <= LAST_ADDR;
	wire [31:0] rd_word = head_mapped ? cfg_reg[head_reg[3:0]] : 32'h00000000;
	wire [31:0] wr_word = {wr_shift_reg[30:0], data_s};
	wire wr_commit = (state_reg == ST_WRITE) & bit_in & (cnt_reg == DATA_LAST)
		& (addr_reg <= LAST_ADDR);
	wire tx_done = (state_reg == ST_READ) & bit_out & (cnt_reg == DATA_BITS);

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_IDLE: begin
				if (selected && cs_fall)
					state_next = ST_HEAD;
			end
			ST_HEAD: begin
				if (head_done)
					state_next = data_s ? ST_READ : ST_WRITE;
			end
			ST_WRITE: begin
				if (bit_in && cnt_reg == DATA_LAST)
					state_next = ST_IDLE;
			end
			ST_READ: begin
				if (tx_done)
					state_next = ST_IDLE;
			end
		endcase
		if (!selected)
			state_next = ST_IDLE;
	end

	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n)
			state_reg <= ST_IDLE;
		else
			state_reg <= state_next;
	end

	// Bit counter and header capture
	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= 6'h00;
			head_reg <= 5'h00;
			addr_reg <= 4'h0;
		end else if (state_reg == ST_IDLE) begin
			cnt_reg <= 6'h00;
		end else if (head_done) begin
			cnt_reg <= 6'h00;
			addr_reg <= head_reg[3:0];
		end else if ((state_reg == ST_READ) ? bit_out : bit_in) begin
			cnt_reg <= cnt_reg + 6'h01;
			head_reg <= {head_reg[3:0], data_s};
		end
	end

	// Write data shifts in on rising edges
	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n)
			wr_shift_reg <= 32'h00000000;
		else if (state_reg == ST_WRITE && bit_in)
			wr_shift_reg <= wr_word;
	end

	// Read data: loaded after the header, driven out on falling edges
	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			tx_reg <= 32'h00000000;
			serial_data_line_out <= 1'b0;
			serial_data_line_oe_out <= 1'b0;
		end else if (state_next != ST_READ) begin
			serial_data_line_oe_out <= 1'b0;
		end else if (head_done) begin
			tx_reg <= rd_word;
		end else if (bit_out) begin
			serial_data_line_out <= tx_reg[31];
			serial_data_line_oe_out <= 1'b1;
			tx_reg <= {tx_reg[30:0], 1'b0};
		end
	end

	// Configuration registers; contents survive shutdown
	for (genvar r = 0; r < NUM_REGS; r++) begin : g_cfg
		always_ff @(posedge clk_sys_in or negedge rst_n) begin
			if (!rst_n)
				cfg_reg[r] <= REG_RESET[r];
			else if (wr_commit && addr_reg == 4'(r))
				cfg_reg[r] <= wr_word;
		end
	end

	wire ext_sel = cfg_reg[ADDR_CLK_CTRL][EXT_CLK_BIT];
	wire dig_mode = cfg_reg[ADDR_OUT_CTRL][DIG_MODE_BIT];
	wire mon_en = cfg_reg[ADDR_OUT_CTRL][MON_EN_BIT];

	// Internal ADC clock as an enable; external clock only as found edges
	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n)
			div_reg <= 3'h0;
		else
			div_reg <= (div_reg == ADC_DIV_LAST) ? 3'h0 : div_reg + 3'h1;
	end
	wire int_tick = div_reg == ADC_DIV_LAST;
	wire smp_strobe = ext_sel ? ext_rise : int_tick;
	wire smp_load = shutdown_low_s & dig_mode & smp_strobe;
	wire smp_clear = ~shutdown_low_s | ~dig_mode;

	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			{q_sample_bit_one_out, q_sample_bit_zero_out} <= 2'b00;
			{i_sample_bit_one_out, i_sample_bit_zero_out} <= 2'b00;
		end else if (smp_clear) begin
			{q_sample_bit_one_out, q_sample_bit_zero_out} <= 2'b00;
			{i_sample_bit_one_out, i_sample_bit_zero_out} <= 2'b00;
		end else if (smp_load) begin
			{q_sample_bit_one_out, q_sample_bit_zero_out} <= smp_s.q;
			{i_sample_bit_one_out, i_sample_bit_zero_out} <= smp_s.i;
		end
	end

	// Monitor stands in for analog I as a differential sign pair
	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			analog_monitor_pos_out <= 1'b0;
			analog_monitor_neg_out <= 1'b0;
			pll_lock_indicator_out <= 1'b0;
			adc_ext_clock_sel_out <= 1'b0;
		end else begin
			analog_monitor_pos_out <= shutdown_low_s & mon_en & smp_s.i[1];
			analog_monitor_neg_out <= shutdown_low_s & mon_en & ~smp_s.i[1];
			pll_lock_indicator_out <= shutdown_low_s & lock_s;
			adc_ext_clock_sel_out <= ext_sel;
		end
	end

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n);

	a_release_on_cs: assert property (cs_s |=> !serial_data_line_oe_out)
		else $error("data line driven while deselected");
	a_shutdown_off: assert property (!shutdown_low_s |=> !pll_lock_indicator_out
		&& !serial_data_line_oe_out && !q_sample_bit_zero_out && !i_sample_bit_one_out)
		else $error("function active during shutdown");
	a_lock_follows: assert property (shutdown_low_s |=> pll_lock_indicator_out == $past(lock_s))
		else $error("lock indicator does not follow PLL");
	a_tx_on_fall: assert property ($changed(serial_data_line_out) |-> $past(sclk_fall))
		else $error("read data changed off a falling edge");
	a_write_lands: assert property (wr_commit |=> cfg_reg[$past(addr_reg)] == $past(wr_word))
		else $error("written word not stored");
	a_read_start: assert property (head_done && data_s |=> state_reg == ST_READ
		##0 tx_reg == $past(rd_word))
		else $error("read header not followed by read");
	a_adc_q_bits: assert property (smp_load |=> {q_sample_bit_one_out, q_sample_bit_zero_out}
		== $past(smp_s.q))
		else $error("Q bits not presented");
	a_adc_i_bits: assert property (smp_load |=> {i_sample_bit_one_out, i_sample_bit_zero_out}
		== $past(smp_s.i))
		else $error("I bits not presented");
	a_ext_clock: assert property (ext_sel && shutdown_low_s && dig_mode && !ext_rise
		|=> $stable({q_sample_bit_one_out, q_sample_bit_zero_out}))
		else $error("sample taken without external clock edge");
	a_monitor_gate: assert property (!mon_en |=> !analog_monitor_pos_out
		&& !analog_monitor_neg_out)
		else $error("monitor active while disabled");
	a_reset_vals: assert property ($rose(rst_n) |-> cfg_reg[0] == REG_RESET[0]
		&& cfg_reg[9] == REG_RESET[9])
		else $error("register reset value wrong");
	a_drive_in_read: assert property (serial_data_line_oe_out |-> state_reg == ST_READ)
		else $error("data line driven outside a read");

	c_write_done: cover property (wr_commit);
	c_read_done: cover property (tx_done);
	c_ext_sample: cover property (smp_load && ext_sel);
	c_monitor_on: cover property (analog_monitor_pos_out);
endmodule : rx_ctrl_serial
`default_nettype wire

// >>> test/host_model.sv
// Host controller model for the three-wire configuration link
`timescale 1ns/1ps
`default_nettype none
module host_model (
	// Three-wire link
	output logic chip_select_low_out,
	output logic serial_clock_out,
	output logic data_out,
	input wire logic data_line_in
);
	localparam realtime HALF = 62.5;
	initial begin
		chip_select_low_out = 1'b1;
		serial_clock_out = 1'b0;
		data_out = 1'b0;
	end
	// Address, read flag and 32 data bits inside one select low
	task automatic frame(input logic [3:0] addr, input logic rd, input logic [31:0] wdata,
		output logic [31:0] rdata);
		logic [36:0] bits;
		bits = {addr, rd, wdata};
		rdata = '0;
		chip_select_low_out = 1'b0;
		for (int k = 36; k >= 0; k--) begin
			// Released line toggles so a stale level cannot pass as read data
			data_out = (rd && k < 32) ? ~data_out : bits[k];
			#HALF serial_clock_out = 1'b1;
			if (k < 32) rdata[k] = data_line_in;
			#HALF serial_clock_out = 1'b0;
		end
		#HALF chip_select_low_out = 1'b1;
		#(4 * HALF);
	endtask : frame
	// Clock activity with select high
	task automatic idle_clocks(input int n);
		for (int k = 0; k < n; k++) begin
			data_out = ~data_out;
			#HALF serial_clock_out = 1'b1;
			#HALF serial_clock_out = 1'b0;
		end
	endtask : idle_clocks
endmodule : host_model
`default_nettype wire

// >>> test/tb.sv
// Testbench for the receiver control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin errors++; \
	$display("ERROR %s expected %h seen %h", nm, exp, got); end end
module tb;
	import rx_ctrl_pkg::*;
	logic clk_sys_in, arst_n_in, shutdown_low_in, pll_locked_in, ext_clk;
	adc_sample_s adc_sample_in;
	wire logic cs_low, sclk, host_d, sdl, sd_out, sd_oe, lock_out, ext_sel;
	wire logic q0, q1, i0, i1, mon_p, mon_n;
	int errors = 0;
	int n_checks = 0;
	int cycles = 0;
	logic [31:0] r0, r9;
	assign sdl = sd_oe ? sd_out : host_d;
	host_model i_host (.chip_select_low_out(cs_low), .serial_clock_out(sclk),
		.data_out(host_d), .data_line_in(sdl));
	rx_ctrl_serial i_dut (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
		.chip_select_low_in(cs_low), .serial_clock_in(sclk), .serial_data_line_in(sdl),
		.serial_data_line_out(sd_out), .serial_data_line_oe_out(sd_oe),
		.shutdown_low_in(shutdown_low_in), .pll_locked_in(pll_locked_in),
		.external_adc_clock_input_in(ext_clk), .adc_sample_in(adc_sample_in),
		.pll_lock_indicator_out(lock_out), .adc_ext_clock_sel_out(ext_sel),
		.q_sample_bit_zero_out(q0), .q_sample_bit_one_out(q1),
		.i_sample_bit_zero_out(i0), .i_sample_bit_one_out(i1),
		.analog_monitor_pos_out(mon_p), .analog_monitor_neg_out(mon_n));
	initial begin
		clk_sys_in = 1'b0;
		forever #4 clk_sys_in = ~clk_sys_in;
	end
	// Ceiling well above the roughly 20000 cycles the scenarios need
	always @(posedge clk_sys_in) begin
		cycles++;
		if (cycles == 40000) begin
			errors++;
			stop_test();
		end
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys_in);
		#1;
	endtask : tick
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		logic [31:0] r;
		i_host.frame(a, 1'b0, d, r);
		tick(1);
	endtask : wr
	task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
		logic [31:0] r;
		i_host.frame(a, 1'b1, 32'h0, r);
		tick(1);
		`CHK("read data", exp, r);
	endtask : rd_chk
	task automatic t_reset_vals();
		for (int a = 0; a < NUM_REGS; a++) rd_chk(a[3:0], REG_RESET[a]);
		rd_chk(4'hB, 32'h0);
	endtask : t_reset_vals
	task automatic t_idle();
		i_host.idle_clocks(40);
		`CHK("oe idle", 1'b0, sd_oe);
		rd_chk(4'h0, REG_RESET[0]);
	endtask : t_idle
	task automatic t_required();
		r0 = REG_RESET[0];
		r0[29:22] = 8'hFA;
		r9 = REG_RESET[9];
		r9[24:22] = 3'h3;
		wr(4'h0, r0);
		wr(4'h9, r9);
		wr(4'hB, 32'hFFFFFFFF);
		rd_chk(4'h0, r0);
		rd_chk(4'h9, r9);
		rd_chk(4'hB, 32'h0);
		// A word unlike the reset value proves the write, and reset restores it
		wr(4'hA, ~REG_RESET[10]);
		rd_chk(4'hA, ~REG_RESET[10]);
		arst_n_in = 1'b0;
		tick(6);
		arst_n_in = 1'b1;
		tick(6);
		rd_chk(4'hA, REG_RESET[10]);
	endtask : t_required
	task automatic t_lock();
		pll_locked_in = 1'b1;
		tick(6);
		`CHK("lock", 1'b1, lock_out);
		pll_locked_in = 1'b0;
		tick(6);
		`CHK("lock", 1'b0, lock_out);
	endtask : t_lock
	task automatic t_samples();
		adc_sample_in = 4'h9;
		tick(24);
		`CHK("samples", 4'h9, {i1, i0, q1, q0});
		adc_sample_in = 4'h6;
		tick(24);
		`CHK("samples", 4'h6, {i1, i0, q1, q0});
		// Samples are only presented in digital output mode
		wr(ADDR_OUT_CTRL, REG_RESET[6] & ~(32'h1 << DIG_MODE_BIT));
		`CHK("analog mode", 4'h0, {i1, i0, q1, q0});
		wr(ADDR_OUT_CTRL, REG_RESET[6]);
		tick(24);
		`CHK("samples", 4'h6, {i1, i0, q1, q0});
	endtask : t_samples
	task automatic t_monitor();
		`CHK("monitor off", 2'h0, {mon_p, mon_n});
		wr(ADDR_OUT_CTRL, REG_RESET[6] | (32'h1 << MON_EN_BIT));
		adc_sample_in = 4'h8;
		tick(24);
		`CHK("monitor", 2'h2, {mon_p, mon_n});
		adc_sample_in = 4'h0;
		tick(24);
		`CHK("monitor", 2'h1, {mon_p, mon_n});
		wr(ADDR_OUT_CTRL, REG_RESET[6]);
		`CHK("monitor off", 2'h0, {mon_p, mon_n});
	endtask : t_monitor
	task automatic t_ext();
		wr(ADDR_CLK_CTRL, REG_RESET[7] | 32'h1);
		`CHK("ext select", 1'b1, ext_sel);
		adc_sample_in = 4'h5;
		tick(40);
		`CHK("held samples", 4'h0, {i1, i0, q1, q0});
		ext_clk = 1'b1;
		tick(8);
		ext_clk = 1'b0;
		tick(8);
		`CHK("ext samples", 4'h5, {i1, i0, q1, q0});
		wr(ADDR_CLK_CTRL, REG_RESET[7]);
	endtask : t_ext
	task automatic t_shutdown();
		pll_locked_in = 1'b1;
		adc_sample_in = 4'hF;
		tick(24);
		shutdown_low_in = 1'b0;
		tick(8);
		`CHK("shutdown outs", 5'h00, {lock_out, i1, i0, q1, q0});
		wr(4'h1, 32'h0);
		shutdown_low_in = 1'b1;
		tick(8);
		`CHK("lock", 1'b1, lock_out);
		rd_chk(4'h1, REG_RESET[1]);
	endtask : t_shutdown
	task automatic stop_test();
		$display("errors %0d checks %0d", errors, n_checks);
		if (errors == 0 && n_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : stop_test
	initial begin
		arst_n_in = 1'b0;
		shutdown_low_in = 1'b1;
		pll_locked_in = 1'b0;
		ext_clk = 1'b0;
		adc_sample_in = '0;
		tick(6);
		arst_n_in = 1'b1;
		tick(6);
		t_reset_vals();
		t_idle();
		t_required();
		t_lock();
		t_samples();
		t_monitor();
		t_ext();
		t_shutdown();
		stop_test();
	end
endmodule : tb
`default_nettype wire
